// File: rtl/ipb_regs.svh
// Register offsets, field positions, reset values and timing for the I2C proxy bridge
// Function
// - Local I2C slave works at bus rates up to 100 kbps.
// - SCL and SDA are open drain: pull low for zero, release for one.
// - Role input high makes the block a slave proxy for the remote slave.
// - Role input low makes the block a master proxy issuing local transactions.
// - Slave proxy forwards every byte for a remote target over the link.
// - Hold SCL low before the ninth clock until the remote answer arrives.
// - Stretch is about 12 us per remote byte; hosts must tolerate it.
// - Physical slave address comes from one strapped six-level address input.
// - Serializer strap levels give addresses 0x58 to 0x5C and 0x5E.
// - Deserializer strap levels give addresses 0x60 to 0x64 and 0x66.
// - Camera use: deserializer forwards commands, serializer runs them and replies.
// - Deserializer holds serializer address at 0x07 and match table 0x08-0x17.
// - Acknowledge an address byte only when the own address or a programmed address matches.
// - Display use: serializer decides local or remote and forwards remote commands.
// - Display use: serializer holds deserializer address 0x06, target address 0x07.
// - Serializer strapped address can be overridden through its own address register.
// - Deserializer logical address comes from the value programmed into the serializer.
`ifndef IPB_REGS_SVH
`define IPB_REGS_SVH

`define IPB_REG_OWN_ADDR 5'h00
`define IPB_REG_STATUS 5'h01
`define IPB_REG_DES_ADDR 5'h06
`define IPB_REG_TGT_ADDR 5'h07
`define IPB_REG_TBL_FIRST 5'h08
`define IPB_REG_TBL_LAST 5'h17
`define IPB_REG_COUNT 24
`define IPB_REG_RESET 8'h00
`define IPB_OWN_OVR_BIT 0
`define IPB_TIMEOUT_DATA 8'hff

`define IPB_SER_ADDR0 7'h58
`define IPB_SER_ADDR1 7'h59
`define IPB_SER_ADDR2 7'h5a
`define IPB_SER_ADDR3 7'h5b
`define IPB_SER_ADDR4 7'h5c
`define IPB_SER_ADDR5 7'h5e
`define IPB_DES_ADDR0 7'h60
`define IPB_DES_ADDR1 7'h61
`define IPB_DES_ADDR2 7'h62
`define IPB_DES_ADDR3 7'h63
`define IPB_DES_ADDR4 7'h64
`define IPB_DES_ADDR5 7'h66

`define IPB_CLK_HZ 100000000
`define IPB_I2C_MAX_BPS 100000
`define IPB_QUARTER_CYC ((`IPB_CLK_HZ + `IPB_I2C_MAX_BPS * 4 - 1) / (`IPB_I2C_MAX_BPS * 4))
`define IPB_STRETCH_TYP_US 12
`define IPB_RESP_TIMEOUT_US 1000
`define IPB_RESP_TIMEOUT_CYC (`IPB_RESP_TIMEOUT_US * (`IPB_CLK_HZ / 1000000))
`define IPB_LINK_FRAME_BITS 10
`define IPB_STRAP_SETTLE 3'h6

`endif

// File: rtl/ipb_pkg.sv
// Types shared by the I2C proxy bridge
package ipb_pkg;
  typedef enum logic [1:0] {
    IPB_OP_START = 2'h0,
    IPB_OP_WR = 2'h1,
    IPB_OP_RD = 2'h2,
    IPB_OP_STOP = 2'h3
  } ipb_op_t;

  typedef struct packed {
    ipb_op_t op;
    logic [7:0] data;
  } ipb_frame_t;

  typedef enum logic [6:0] {
    IPB_S_IDLE = 7'h01,
    IPB_S_RX = 7'h02,
    IPB_S_WAIT = 7'h04,
    IPB_S_ACK = 7'h08,
    IPB_S_TX = 7'h10,
    IPB_S_RACK = 7'h20,
    IPB_S_IGN = 7'h40
  } ipb_sl_state_t;

  typedef enum logic [3:0] {
    IPB_M_IDLE = 4'h1,
    IPB_M_START = 4'h2,
    IPB_M_BITS = 4'h4,
    IPB_M_STOP = 4'h8
  } ipb_ms_state_t;

  typedef enum logic [1:0] {
    IPB_TGT_NONE = 2'h0,
    IPB_TGT_LOCAL = 2'h1,
    IPB_TGT_REMOTE = 2'h2
  } ipb_tgt_t;
endpackage

// File: rtl/ipb_bridge.sv
// I2C proxy bridge: slave proxy, master proxy, local registers and control link
`timescale 1ns/1ps
`default_nettype none
`include "ipb_regs.svh"
module ipb_bridge #(
  parameter int unsigned RESP_TIMEOUT_CYC = `IPB_RESP_TIMEOUT_CYC,
  parameter bit IS_SER = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic role_sel_i,
  input wire logic [2:0] address_strap_input_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic link_clk_i,
  input wire logic link_rx_frame_i,
  input wire logic link_rx_data_i,
  output logic link_tx_frame_o,
  output logic link_tx_data_o,
  output ipb_pkg::ipb_tgt_t proxy_target_o,
  output logic proxy_busy_o
);
  import ipb_pkg::*;

  localparam int unsigned QCYC = `IPB_QUARTER_CYC;
  localparam int unsigned TW = $clog2(RESP_TIMEOUT_CYC + 1);
  localparam int unsigned QW = $clog2(QCYC + 1);
  localparam int unsigned NSYNC = 9;
  localparam logic [NSYNC-1:0] SYNC_RST = 9'h003;
  localparam logic [3:0] FRAME_LAST = 4'(`IPB_LINK_FRAME_BITS - 1);

  // Three-stage synchronisers, value taken when stages two and three agree
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] filt;
  assign raw_in = {address_strap_input_i, role_sel_i, link_rx_data_i, link_rx_frame_i,
                   link_clk_i, sda_i, scl_i};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      logic [2:0] s_ff;
      logic f_ff;
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s_ff <= {3{SYNC_RST[gi]}};
          f_ff <= SYNC_RST[gi];
        end else begin
          s_ff <= {s_ff[1:0], raw_in[gi]};
          if (s_ff[1] == s_ff[2]) begin
            f_ff <= s_ff[2];
          end
        end
      end
      assign filt[gi] = f_ff;
    end
  endgenerate

  logic bus_scl, bus_sda, lclk, lfrm, ldat;
  assign bus_scl = filt[0];
  assign bus_sda = filt[1];
  assign lclk = filt[2];
  assign lfrm = filt[3];
  assign ldat = filt[4];

  logic [2:0] prev_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff <= 3'h3;
    end else begin
      prev_ff <= {lclk, bus_sda, bus_scl};
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c, lclk_rise, lclk_fall;
  assign scl_rise = bus_scl & ~prev_ff[0];
  assign scl_fall = ~bus_scl & prev_ff[0];
  assign start_c = bus_scl & prev_ff[0] & prev_ff[1] & ~bus_sda;
  assign stop_c = bus_scl & prev_ff[0] & ~prev_ff[1] & bus_sda;
  assign lclk_rise = lclk & ~prev_ff[2];
  assign lclk_fall = ~lclk & prev_ff[2];

  // Straps caught once, after the synchronisers settle
  logic [2:0] cap_cnt_ff;
  logic role_ff;
  logic [2:0] strap_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_cnt_ff <= 3'h0;
      role_ff <= 1'b0;
      strap_ff <= 3'h0;
    end else if (cap_cnt_ff != `IPB_STRAP_SETTLE) begin
      cap_cnt_ff <= cap_cnt_ff + 3'h1;
      if (cap_cnt_ff == `IPB_STRAP_SETTLE - 3'h1) begin
        role_ff <= filt[5];
        strap_ff <= filt[8:6];
      end
    end
  end

  logic [6:0] strap_addr;
  always_comb begin
    case (strap_ff)
      3'h0: strap_addr = IS_SER ? `IPB_SER_ADDR0 : `IPB_DES_ADDR0;
      3'h1: strap_addr = IS_SER ? `IPB_SER_ADDR1 : `IPB_DES_ADDR1;
      3'h2: strap_addr = IS_SER ? `IPB_SER_ADDR2 : `IPB_DES_ADDR2;
      3'h3: strap_addr = IS_SER ? `IPB_SER_ADDR3 : `IPB_DES_ADDR3;
      3'h4: strap_addr = IS_SER ? `IPB_SER_ADDR4 : `IPB_DES_ADDR4;
      default: strap_addr = IS_SER ? `IPB_SER_ADDR5 : `IPB_DES_ADDR5;
    endcase
  end

  // Register file
  logic [7:0] regs_ff [`IPB_REG_COUNT];
  logic reg_we_ff;
  logic [4:0] reg_wa_ff;
  logic [7:0] reg_wd_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `IPB_REG_COUNT; i++) begin
        regs_ff[i] <= `IPB_REG_RESET;
      end
    end else if (reg_we_ff && reg_wa_ff != `IPB_REG_STATUS
                 && reg_wa_ff <= `IPB_REG_TBL_LAST) begin
      regs_ff[reg_wa_ff] <= reg_wd_ff;
    end
  end

  logic [6:0] own_addr;
  assign own_addr = (IS_SER && regs_ff[`IPB_REG_OWN_ADDR][`IPB_OWN_OVR_BIT])
                    ? regs_ff[`IPB_REG_OWN_ADDR][7:1] : strap_addr;

  logic [7:0] sh_ff;
  logic [15:0] tbl_hit;
  logic remote_hit;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_match
      assign tbl_hit[gi] = !IS_SER && regs_ff[`IPB_REG_TBL_FIRST + gi][7:1] != 7'h00
                           && regs_ff[`IPB_REG_TBL_FIRST + gi][7:1] == sh_ff[7:1];
    end
  endgenerate
  always_comb begin
    remote_hit = |tbl_hit;
    if (IS_SER && regs_ff[`IPB_REG_DES_ADDR][7:1] != 7'h00
        && regs_ff[`IPB_REG_DES_ADDR][7:1] == sh_ff[7:1]) begin
      remote_hit = 1'b1;
    end
    if (regs_ff[`IPB_REG_TGT_ADDR][7:1] != 7'h00
        && regs_ff[`IPB_REG_TGT_ADDR][7:1] == sh_ff[7:1]) begin
      remote_hit = 1'b1;
    end
  end

  logic busy_ff;
  ipb_tgt_t tgt_ff;
  logic [4:0] ptr_ff;
  logic [7:0] rd_val;
  always_comb begin
    if (ptr_ff == `IPB_REG_STATUS) begin
      rd_val = {role_ff, busy_ff, tgt_ff == IPB_TGT_REMOTE, 2'h0, strap_ff};
    end else if (ptr_ff <= `IPB_REG_TBL_LAST) begin
      rd_val = regs_ff[ptr_ff];
    end else begin
      rd_val = 8'h00;
    end
  end

  // Link receiver: sampled on rising link clock while the frame is up
  logic [3:0] rx_cnt_ff;
  logic [9:0] rx_sh_ff;
  logic rx_valid_ff;
  ipb_frame_t rx_frame;
  assign rx_frame = rx_sh_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_cnt_ff <= 4'h0;
      rx_sh_ff <= 10'h000;
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= 1'b0;
      if (!lfrm) begin
        rx_cnt_ff <= 4'h0;
      end else if (lclk_rise) begin
        rx_sh_ff <= {rx_sh_ff[8:0], ldat};
        rx_valid_ff <= rx_cnt_ff == FRAME_LAST;
        rx_cnt_ff <= (rx_cnt_ff == FRAME_LAST) ? 4'h0 : rx_cnt_ff + 4'h1;
      end
    end
  end

  // Link transmitter: bits change on falling link clock
  logic sl_req_ff, ms_req_ff;
  ipb_frame_t sl_word_ff, ms_word_ff;
  logic tx_pend_ff;
  logic [9:0] tx_word_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_frame_ff, tx_data_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_pend_ff <= 1'b0;
      tx_word_ff <= 10'h000;
      tx_cnt_ff <= 4'h0;
      tx_frame_ff <= 1'b0;
      tx_data_ff <= 1'b0;
    end else begin
      if (role_ff ? sl_req_ff : ms_req_ff) begin
        tx_pend_ff <= 1'b1;
        tx_word_ff <= role_ff ? sl_word_ff : ms_word_ff;
      end else if (lclk_fall) begin
        if (!tx_frame_ff && tx_pend_ff) begin
          tx_frame_ff <= 1'b1;
          tx_data_ff <= tx_word_ff[9];
          tx_word_ff <= {tx_word_ff[8:0], 1'b0};
          tx_cnt_ff <= FRAME_LAST;
          tx_pend_ff <= 1'b0;
        end else if (tx_frame_ff) begin
          if (tx_cnt_ff == 4'h0) begin
            tx_frame_ff <= 1'b0;
            tx_data_ff <= 1'b0;
          end else begin
            tx_data_ff <= tx_word_ff[9];
            tx_word_ff <= {tx_word_ff[8:0], 1'b0};
            tx_cnt_ff <= tx_cnt_ff - 4'h1;
          end
        end
      end
    end
  end

  // Slave proxy
  ipb_sl_state_t s_st_ff;
  logic [3:0] bcnt_ff;
  logic is_addr_ff, rw_ff, first_wr_ff, ack_ff, sess_ff, got_ff, to_tx_ff, more_ff;
  logic sl_scl_oe_ff, sl_sda_oe_ff;
  logic [TW-1:0] tmr_ff;
  logic do_fetch;
  assign do_fetch = scl_fall && ((s_st_ff == IPB_S_ACK && ack_ff && rw_ff)
                                 || (s_st_ff == IPB_S_RACK && more_ff));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_st_ff <= IPB_S_IDLE;
      bcnt_ff <= 4'h0;
      sh_ff <= 8'h00;
      is_addr_ff <= 1'b0;
      rw_ff <= 1'b0;
      first_wr_ff <= 1'b0;
      ack_ff <= 1'b0;
      sess_ff <= 1'b0;
      got_ff <= 1'b0;
      to_tx_ff <= 1'b0;
      more_ff <= 1'b0;
      tgt_ff <= IPB_TGT_NONE;
      ptr_ff <= 5'h00;
      sl_scl_oe_ff <= 1'b0;
      sl_sda_oe_ff <= 1'b0;
      sl_req_ff <= 1'b0;
      sl_word_ff <= '0;
      tmr_ff <= '0;
      reg_we_ff <= 1'b0;
      reg_wa_ff <= 5'h00;
      reg_wd_ff <= 8'h00;
    end else begin
      sl_req_ff <= 1'b0;
      reg_we_ff <= 1'b0;
      if (!role_ff) begin
        s_st_ff <= IPB_S_IDLE;
        sl_scl_oe_ff <= 1'b0;
        sl_sda_oe_ff <= 1'b0;
        sess_ff <= 1'b0;
      end else if (start_c) begin
        s_st_ff <= IPB_S_RX;
        bcnt_ff <= 4'h0;
        is_addr_ff <= 1'b1;
        sl_sda_oe_ff <= 1'b0;
      end else if (stop_c) begin
        if (sess_ff) begin
          sl_req_ff <= 1'b1;
          sl_word_ff <= {IPB_OP_STOP, 8'h00};
        end
        sess_ff <= 1'b0;
        sl_sda_oe_ff <= 1'b0;
        s_st_ff <= IPB_S_IDLE;
      end else begin
        case (s_st_ff)
          IPB_S_RX: begin
            if (scl_rise) begin
              sh_ff <= {sh_ff[6:0], bus_sda};
              bcnt_ff <= bcnt_ff + 4'h1;
            end else if (scl_fall && bcnt_ff == 4'h8) begin
              bcnt_ff <= 4'h0;
              if (is_addr_ff) begin
                is_addr_ff <= 1'b0;
                rw_ff <= sh_ff[0];
                first_wr_ff <= 1'b1;
                if (sh_ff[7:1] == own_addr) begin
                  tgt_ff <= IPB_TGT_LOCAL;
                  ack_ff <= 1'b1;
                  sl_sda_oe_ff <= 1'b1;
                  s_st_ff <= IPB_S_ACK;
                end else if (remote_hit) begin
                  tgt_ff <= IPB_TGT_REMOTE;
                  sess_ff <= 1'b1;
                  sl_scl_oe_ff <= 1'b1;
                  sl_req_ff <= 1'b1;
                  sl_word_ff <= {IPB_OP_START, sh_ff};
                  got_ff <= 1'b0;
                  to_tx_ff <= 1'b0;
                  tmr_ff <= TW'(RESP_TIMEOUT_CYC);
                  s_st_ff <= IPB_S_WAIT;
                end else begin
                  tgt_ff <= IPB_TGT_NONE;
                  s_st_ff <= IPB_S_IGN;
                end
              end else if (tgt_ff == IPB_TGT_LOCAL) begin
                first_wr_ff <= 1'b0;
                if (first_wr_ff) begin
                  ptr_ff <= sh_ff[4:0];
                end else begin
                  reg_we_ff <= 1'b1;
                  reg_wa_ff <= ptr_ff;
                  reg_wd_ff <= sh_ff;
                  ptr_ff <= ptr_ff + 5'h01;
                end
                ack_ff <= 1'b1;
                sl_sda_oe_ff <= 1'b1;
                s_st_ff <= IPB_S_ACK;
              end else begin
                sl_scl_oe_ff <= 1'b1;
                sl_req_ff <= 1'b1;
                sl_word_ff <= {IPB_OP_WR, sh_ff};
                got_ff <= 1'b0;
                to_tx_ff <= 1'b0;
                tmr_ff <= TW'(RESP_TIMEOUT_CYC);
                s_st_ff <= IPB_S_WAIT;
              end
            end
          end
          IPB_S_WAIT: begin
            if (!got_ff) begin
              if (rx_valid_ff) begin
                got_ff <= 1'b1;
                tmr_ff <= TW'(QCYC);
                if (to_tx_ff) begin
                  sh_ff <= rx_frame.data;
                  sl_sda_oe_ff <= ~rx_frame.data[7];
                end else begin
                  ack_ff <= rx_frame.op[0];
                  sl_sda_oe_ff <= rx_frame.op[0];
                end
              end else if (tmr_ff == '0) begin
                got_ff <= 1'b1;
                tmr_ff <= TW'(QCYC);
                ack_ff <= 1'b0;
                sl_sda_oe_ff <= 1'b0;
                sh_ff <= `IPB_TIMEOUT_DATA;
              end else begin
                tmr_ff <= tmr_ff - 1'b1;
              end
            end else if (tmr_ff == '0) begin
              sl_scl_oe_ff <= 1'b0;
              bcnt_ff <= 4'h0;
              s_st_ff <= to_tx_ff ? IPB_S_TX : IPB_S_ACK;
            end else begin
              tmr_ff <= tmr_ff - 1'b1;
            end
          end
          IPB_S_ACK: begin
            if (scl_fall) begin
              sl_sda_oe_ff <= 1'b0;
              if (!ack_ff) begin
                s_st_ff <= IPB_S_IGN;
              end else if (!rw_ff) begin
                s_st_ff <= IPB_S_RX;
              end
            end
          end
          IPB_S_TX: begin
            if (scl_fall) begin
              if (bcnt_ff == 4'h7) begin
                sl_sda_oe_ff <= 1'b0;
                s_st_ff <= IPB_S_RACK;
              end else begin
                sl_sda_oe_ff <= ~sh_ff[6];
                sh_ff <= {sh_ff[6:0], 1'b1};
                bcnt_ff <= bcnt_ff + 4'h1;
              end
            end
          end
          IPB_S_RACK: begin
            if (scl_rise) begin
              more_ff <= ~bus_sda;
            end else if (scl_fall && !more_ff) begin
              s_st_ff <= IPB_S_IGN;
            end
          end
          IPB_S_IDLE, IPB_S_IGN: begin
            sl_sda_oe_ff <= 1'b0;
          end
          default: s_st_ff <= IPB_S_IDLE;
        endcase
        if (do_fetch) begin
          bcnt_ff <= 4'h0;
          if (tgt_ff == IPB_TGT_LOCAL) begin
            sh_ff <= rd_val;
            sl_sda_oe_ff <= ~rd_val[7];
            ptr_ff <= ptr_ff + 5'h01;
            s_st_ff <= IPB_S_TX;
          end else begin
            sl_sda_oe_ff <= 1'b0;
            sl_scl_oe_ff <= 1'b1;
            sl_req_ff <= 1'b1;
            sl_word_ff <= {IPB_OP_RD, 8'h01};
            got_ff <= 1'b0;
            to_tx_ff <= 1'b1;
            tmr_ff <= TW'(RESP_TIMEOUT_CYC);
            s_st_ff <= IPB_S_WAIT;
          end
        end
      end
    end
  end

  // Master proxy: quarter-bit sequencer at no more than 100 kbps
  ipb_ms_state_t m_st_ff;
  logic [1:0] ph_ff;
  logic [3:0] mbit_ff;
  logic [7:0] mwsh_ff, mrsh_ff;
  logic m_wr_ff, m_ackreq_ff, m_ack_ff, ms_scl_oe_ff, ms_sda_oe_ff;
  logic [QW-1:0] mtmr_ff;
  logic m_drv;
  assign m_drv = (mbit_ff < 4'h8) ? (m_wr_ff ? mwsh_ff[7] : 1'b1)
                                  : (m_wr_ff ? 1'b1 : ~m_ackreq_ff);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m_st_ff <= IPB_M_IDLE;
      ph_ff <= 2'h0;
      mbit_ff <= 4'h0;
      mwsh_ff <= 8'h00;
      mrsh_ff <= 8'h00;
      m_wr_ff <= 1'b0;
      m_ackreq_ff <= 1'b0;
      m_ack_ff <= 1'b0;
      ms_scl_oe_ff <= 1'b0;
      ms_sda_oe_ff <= 1'b0;
      ms_req_ff <= 1'b0;
      ms_word_ff <= '0;
      mtmr_ff <= '0;
    end else begin
      ms_req_ff <= 1'b0;
      if (role_ff) begin
        m_st_ff <= IPB_M_IDLE;
        ms_scl_oe_ff <= 1'b0;
        ms_sda_oe_ff <= 1'b0;
      end else if (m_st_ff == IPB_M_IDLE) begin
        if (rx_valid_ff) begin
          ph_ff <= 2'h0;
          mbit_ff <= 4'h0;
          mtmr_ff <= QW'(QCYC);
          mwsh_ff <= rx_frame.data;
          m_wr_ff <= rx_frame.op != IPB_OP_RD;
          m_ackreq_ff <= rx_frame.data[0];
          case (rx_frame.op)
            IPB_OP_START: m_st_ff <= IPB_M_START;
            IPB_OP_STOP: m_st_ff <= IPB_M_STOP;
            default: m_st_ff <= IPB_M_BITS;
          endcase
        end
      end else if (mtmr_ff != '0) begin
        mtmr_ff <= mtmr_ff - 1'b1;
      end else if (ph_ff == 2'h2 && !bus_scl) begin
        mtmr_ff <= '0;
      end else begin
        mtmr_ff <= QW'(QCYC);
        ph_ff <= ph_ff + 2'h1;
        case (m_st_ff)
          IPB_M_START: begin
            case (ph_ff)
              2'h0: ms_sda_oe_ff <= 1'b0;
              2'h1: ms_scl_oe_ff <= 1'b0;
              2'h2: ms_sda_oe_ff <= 1'b1;
              default: begin
                ms_scl_oe_ff <= 1'b1;
                m_st_ff <= IPB_M_BITS;
              end
            endcase
          end
          IPB_M_BITS: begin
            case (ph_ff)
              2'h0: ms_sda_oe_ff <= ~m_drv;
              2'h1: ms_scl_oe_ff <= 1'b0;
              2'h2: begin
                if (mbit_ff < 4'h8) begin
                  mrsh_ff <= {mrsh_ff[6:0], bus_sda};
                end else begin
                  m_ack_ff <= ~bus_sda;
                end
              end
              default: begin
                ms_scl_oe_ff <= 1'b1;
                mwsh_ff <= {mwsh_ff[6:0], 1'b1};
                mbit_ff <= mbit_ff + 4'h1;
                if (mbit_ff == 4'h8) begin
                  m_st_ff <= IPB_M_IDLE;
                  ms_req_ff <= 1'b1;
                  ms_word_ff <= m_wr_ff ? {ipb_op_t'({1'b0, m_ack_ff}), 8'h00}
                                        : {IPB_OP_WR, mrsh_ff};
                end
              end
            endcase
          end
          IPB_M_STOP: begin
            case (ph_ff)
              2'h0: ms_sda_oe_ff <= 1'b1;
              2'h1: ms_scl_oe_ff <= 1'b0;
              2'h2: ms_sda_oe_ff <= 1'b0;
              default: begin
                m_st_ff <= IPB_M_IDLE;
                ms_req_ff <= 1'b1;
                ms_word_ff <= {IPB_OP_WR, 8'h00};
              end
            endcase
          end
          default: m_st_ff <= IPB_M_IDLE;
        endcase
      end
    end
  end

  // Output stage, role picks which engine owns the pins
  logic scl_oe_ff, sda_oe_ff;
  ipb_tgt_t tgt_o_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      tgt_o_ff <= IPB_TGT_NONE;
    end else begin
      scl_oe_ff <= role_ff ? sl_scl_oe_ff : ms_scl_oe_ff;
      sda_oe_ff <= role_ff ? sl_sda_oe_ff : ms_sda_oe_ff;
      // Pending link frames count as busy, the far end clocks only then
      busy_ff <= (role_ff ? (s_st_ff != IPB_S_IDLE) : (m_st_ff != IPB_M_IDLE))
                 || sl_req_ff || ms_req_ff || tx_pend_ff || tx_frame_ff;
      tgt_o_ff <= role_ff ? tgt_ff : IPB_TGT_NONE;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_oe_ff;
  assign sda_oe_o = sda_oe_ff;
  assign link_tx_frame_o = tx_frame_ff;
  assign link_tx_data_o = tx_data_ff;
  assign proxy_busy_o = busy_ff;
  assign proxy_target_o = tgt_o_ff;
endmodule
`default_nettype wire

// File: verification/ipb_bridge_checker.sv
// Port assertions for the I2C proxy bridge
`timescale 1ns/1ps
`default_nettype none
module ipb_bridge_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic link_tx_frame_o,
  input wire ipb_pkg::ipb_tgt_t proxy_target_o,
  input wire logic proxy_busy_o
);
  import ipb_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_acked;
    $rose(sda_oe_o) && scl_oe_o;
  endsequence
  sequence s_frame;
    $rose(link_tx_frame_o) ##155 link_tx_frame_o;
  endsequence
  a_scl_drive_zero: assert property (scl_o == 1'b0) else $error("scl value");
  a_sda_drive_zero: assert property (sda_o == 1'b0) else $error("sda value");
  a_stretch_remote: assert property ($rose(scl_oe_o) |-> ##[0:4]
    proxy_target_o == IPB_TGT_REMOTE) else $error("stretch not remote");
  a_stretch_on_low: assert property ($rose(scl_oe_o) |-> !$past(scl_i))
    else $error("stretch cut high");
  a_idle_no_stretch: assert property (!proxy_busy_o |-> !scl_oe_o)
    else $error("idle stretch");
  a_frame_ten_bits: assert property (s_frame |-> ##[1:12] !link_tx_frame_o)
    else $error("frame length");
  a_ack_setup_hold: assert property (s_acked |-> ##[200:300] !scl_oe_o)
    else $error("stretch release");
  a_local_no_link: assert property (proxy_target_o == IPB_TGT_LOCAL |->
    !link_tx_frame_o) else $error("local forwarded");
endmodule
bind ipb_bridge ipb_bridge_checker i_chk (.clk_i, .rst_n_i, .scl_i, .scl_o, .scl_oe_o,
  .sda_o, .sda_oe_o, .link_tx_frame_o, .proxy_target_o, .proxy_busy_o);
`default_nettype wire

// File: verification/ipb_far_model.sv
// Far end of the control link: answers every command with an ack frame
`timescale 1ns/1ps
`default_nettype none
module ipb_far_model (
  input wire logic busy_i,
  input wire logic tx_frame_i,
  input wire logic tx_data_i,
  output logic link_clk_o,
  output logic rx_frame_o,
  output logic rx_data_o,
  output logic [9:0] got_o
);
  // Far table cleared, so every command is answered
  localparam logic [9:0] ack_rsp = 10'h100;
  // Last forwarded command, bits taken on rising link clock
  always @(posedge link_clk_o) begin
    if (tx_frame_i) got_o <= {got_o[8:0], tx_data_i};
  end
  initial begin
    link_clk_o = 0;
    forever begin
      #80;
      // Clock stands still when no exchange pending
      if (busy_i || tx_frame_i || rx_frame_o) link_clk_o = !link_clk_o;
    end
  end
  initial begin
    rx_frame_o = 0;
    rx_data_o = 0;
    forever begin
      @(negedge tx_frame_i);
      @(negedge link_clk_o);
      rx_frame_o = 1;
      for (int i = 9; i >= 0; i--) begin
        rx_data_o = ack_rsp[i];
        @(negedge link_clk_o);
      end
      rx_frame_o = 0;
      rx_data_o = !rx_data_o;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the I2C proxy bridge in slave role
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ipb_pkg::*;
  logic clk_i = 0, rst_n_i = 0, hs = 0, hd = 0, lclk, rxf, rxd, txf, txd;
  logic scl_oe, sda_oe, busy, ack, seen_oe;
  logic [9:0] got;
  logic [2:0] strap = 3'h0;
  ipb_tgt_t tgt;
  int bad_count = 0, checked = 0, cyc = 0;
  wire logic scl_w = !(scl_oe || hs);
  wire logic sda_w = !(sda_oe || hd);
  always #5 clk_i = ~clk_i;
  ipb_bridge #(.RESP_TIMEOUT_CYC(2000)) i_dut (.clk_i, .rst_n_i, .role_sel_i(1'b1),
    .address_strap_input_i(strap), .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .link_clk_i(lclk), .link_rx_frame_i(rxf),
    .link_rx_data_i(rxd), .link_tx_frame_o(txf), .link_tx_data_o(txd),
    .proxy_target_o(tgt), .proxy_busy_o(busy));
  ipb_far_model i_far (.busy_i(busy), .tx_frame_i(txf), .tx_data_i(txd), .link_clk_o(lclk),
    .rx_frame_o(rxf), .rx_data_o(rxd), .got_o(got));
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (scl_oe) seen_oe <= 1;
  end
  always @(negedge clk_i) if (cyc == 96000) begin
    bad_count++;
    give_verdict;
  end
  task chk(input logic [7:0] seen, exp, input string nm);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task q; repeat (250) @(negedge clk_i); endtask
  task bt(input logic b, output logic r);
    hd = !b; q; hs = 0;
    for (int i = 0; i < 3000 && !scl_w; i++) @(negedge clk_i);
    q; r = sda_w; q; hs = 1; q;
  endtask
  task start; hd = 0; q; hs = 0; q; hd = 1; q; hs = 1; q; endtask
  task stop; hd = 1; q; hs = 0; q; hd = 0; q; endtask
  task xb(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ack = !r;
  endtask
  task rb(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, r);
      d[i] = r;
    end
    bt(1'b1, r);
  endtask
  task t_reset;
    chk({4'h0, scl_oe, sda_oe, txf, busy}, 8'h00, "outputs");
    chk(8'(tgt), 8'(IPB_TGT_NONE), "target");
    $display("test reset done");
  endtask
  task t_local;
    start; xb(8'hB0);
    chk({7'h0, ack}, 8'h01, "own addr ack");
    xb(8'h06); xb(8'h90); xb(8'hA4);
    chk({7'h0, ack}, 8'h01, "reg ack");
    stop;
    $display("test local done");
  endtask
  task t_remote(input logic [7:0] a);
    seen_oe = 0;
    start; xb(a);
    chk({7'h0, ack}, 8'h01, "remote ack");
    chk(8'(tgt), 8'(IPB_TGT_REMOTE), "remote target");
    chk({7'h0, seen_oe}, 8'h01, "stretch");
    chk(got[7:0], a, "fwd byte");
    chk(8'(got[9:8]), 8'(IPB_OP_START), "fwd op");
    stop;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk_i);
    chk({7'h0, busy}, 8'h00, "idle");
    $display("test remote done");
  endtask
  task t_strap;
    logic [7:0] rd;
    strap = 3'h5; rst_n_i = 0;
    repeat (4) @(negedge clk_i);
    rst_n_i = 1; q;
    start; xb(8'hB0);
    chk({7'h0, ack}, 8'h00, "old addr nack");
    chk(8'(tgt), 8'(IPB_TGT_NONE), "no target");
    stop; start; xb(8'hBD);
    chk({7'h0, ack}, 8'h01, "strap5 ack");
    rb(rd);
    chk(rd, 8'h00, "reg0 read");
    stop;
    $display("test strap done");
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1; q;
    t_reset; t_local; t_remote(8'h90); t_remote(8'hA4); t_strap;
    give_verdict;
  end
endmodule
`default_nettype wire
